// File: hdl/hmf_pkg.sv
// How it works
// - Leading pad bytes, count from the offset field, precede each receive frame.
// - Offset field takes any value 0 to 31 bytes, all five bits used.
// - Upper offset bits may change live; new value applies to next output word.
// - Writing one to the status flush bit empties the transmit status FIFO.
// - Writing one to the data flush bit empties the transmit data FIFO.
// - With overrun-allow clear, transmission suspends while the status FIFO is full.
// - With overrun-allow set, transmission continues with a full status FIFO.
// - Status FIFO full interrupt behaves the same whatever overrun-allow holds.
// - Transmitter enable bit enables the transmitter to send FIFO frame data.
// - Enable bit clears itself once stop was requested and transmitter halted.
// - Stop bit lets the current frame finish, then no further frames are sent.
// - Stop bit clears itself once the transmitter has halted.
// - Writes to the stop bit are ignored while it reads one.
// - Skip bit stays one until the skip finishes, then clears itself.
package hmf_pkg;
   //----------------------------------------
   // Register offsets
   //----------------------------------------
   localparam logic [7:0] REG_RX_CFG_LOW_OFS = 8'h6C;
   localparam logic [7:0] REG_TX_CFG_OFS     = 8'h70;
   localparam logic [7:0] REG_RX_DP_OFS      = 8'h78;
   localparam logic [7:0] REG_IRQ_STS_OFS    = 8'h90;
   localparam logic [7:0] REG_IRQ_MSK_OFS    = 8'h94;

   //----------------------------------------
   // Field positions
   //----------------------------------------
   localparam int RX_OFF_LSB     = 8;
   localparam int RX_OFF_MSB     = 12;
   localparam int TXS_FLUSH_BIT  = 15;
   localparam int TXD_FLUSH_BIT  = 14;
   localparam int TX_SAO_BIT     = 2;
   localparam int TX_ON_BIT      = 1;
   localparam int TX_STOP_BIT    = 0;
   localparam int RX_SKIP_BIT    = 31;
   localparam int IRQ_TSF_BIT    = 0;
   localparam int IRQ_STOP_BIT   = 1;
   localparam int IRQ_SKIP_BIT   = 2;
   localparam int IRQ_W          = 3;

   //----------------------------------------
   // Reset values and codes
   //----------------------------------------
   localparam logic [4:0]       RX_OFF_RST  = 5'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST     = 3'h0;
   localparam logic [1:0]       RESP_OKAY   = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;
   localparam logic [7:0]       PAD_BYTE    = 8'h00;

   typedef enum logic [2:0] {
      SH_PASS = 3'h1,
      SH_PAD  = 3'h2,
      SH_SKIP = 3'h4
   } hmf_shift_state_t;
endpackage

// File: hdl/hmf_rx_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module hmf_rx_shifter
   import hmf_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   // Control
   input  wire logic [4:0] offset_i,
   input  wire logic       skip_req_i,
   output logic            skip_done_o,
   // Byte stream in
   input  wire logic       in_valid_i,
   input  wire logic [7:0] in_data_i,
   input  wire logic       in_sof_i,
   output logic            in_ready_o,
   // Byte stream out
   output logic            out_valid_o,
   output logic [7:0]      out_data_o,
   output logic            out_sof_o
);
   typedef struct packed {
      hmf_shift_state_t st;
      logic [4:0]       cnt;
      logic [7:0]       hold;
      logic             ready;
      logic             ovalid;
      logic [7:0]       odata;
      logic             osof;
      logic             done;
   } hmf_shift_t;

   localparam hmf_shift_t SH_RST = '{st: SH_PASS, default: '0};

   hmf_shift_t q;
   hmf_shift_t n;
   logic       take;

   always_comb begin
      n = q;
      n.ovalid = 1'b0;
      n.done = 1'b0;
      take = in_valid_i && q.ready;
      unique case (q.st)
         SH_PASS, SH_SKIP: begin
            if (take && in_sof_i) begin
               n.done = (q.st == SH_SKIP);
               if (offset_i != RX_OFF_RST) begin
                  n.hold = in_data_i;
                  n.ovalid = 1'b1;
                  n.odata = PAD_BYTE;
                  n.osof = 1'b1;
                  n.cnt = 5'h01;
                  n.st = SH_PAD;
               end else begin
                  n.ovalid = 1'b1;
                  n.odata = in_data_i;
                  n.osof = 1'b1;
                  n.st = SH_PASS;
               end
            end else if (take && q.st == SH_PASS) begin
               n.ovalid = 1'b1;
               n.odata = in_data_i;
               n.osof = 1'b0;
            end
            // Request still high the cycle after done; no re-entry
            if (q.st == SH_PASS && n.st == SH_PASS && skip_req_i && !q.done) begin
               n.st = SH_SKIP;
            end
         end
         SH_PAD: begin
            n.ovalid = 1'b1;
            n.osof = 1'b0;
            // Live offset compare, so upper bits act on the next word
            if (q.cnt < offset_i) begin
               n.odata = PAD_BYTE;
               n.cnt = q.cnt + 5'h01;
            end else begin
               n.odata = q.hold;
               n.st = SH_PASS;
            end
         end
      endcase
      n.ready = (n.st != SH_PAD);
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q <= SH_RST;
      end else begin
         q <= n;
      end
   end

   assign in_ready_o  = q.ready;
   assign out_valid_o = q.ovalid;
   assign out_data_o  = q.odata;
   assign out_sof_o   = q.osof;
   assign skip_done_o = q.done;
endmodule
`default_nettype wire

// File: hdl/hmf_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module hmf_top
   import hmf_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   output logic             s_axi_awready_o,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid_i,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   output logic             s_axi_wready_o,
   // AXI4-Lite write response
   output logic             s_axi_bvalid_o,
   output logic [1:0]       s_axi_bresp_o,
   input  wire logic        s_axi_bready_i,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   output logic             s_axi_arready_o,
   // AXI4-Lite read data
   output logic             s_axi_rvalid_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   input  wire logic        s_axi_rready_i,
   // Transmit engine
   input  wire logic        tx_halted_i,
   input  wire logic        tx_status_fifo_full_i,
   output logic             tx_enable_o,
   output logic             tx_stop_req_o,
   output logic             tx_suspend_o,
   output logic             tx_status_flush_o,
   output logic             tx_data_flush_o,
   // Receive byte stream in
   input  wire logic        rx_in_valid_i,
   input  wire logic [7:0]  rx_in_data_i,
   input  wire logic        rx_in_sof_i,
   output logic             rx_in_ready_o,
   // Receive byte stream out
   output logic             rx_out_valid_o,
   output logic [7:0]       rx_out_data_o,
   output logic             rx_out_sof_o,
   // Interrupt
   output logic             irq_o
);
   //----------------------------------------
   // State
   //----------------------------------------
   typedef struct packed {
      logic             awready;
      logic             aw_got;
      logic [7:0]       aw_addr;
      logic             wready;
      logic             w_got;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic [4:0]       rx_payload_byte_offset;
      logic             tx_status_overrun_allow;
      logic             tx_on;
      logic             tx_stop;
      logic             rx_frame_skip;
      logic             tx_status_flush;
      logic             tx_data_flush;
      logic             tx_suspend;
      logic [IRQ_W-1:0] irq_sts;
      logic [IRQ_W-1:0] irq_msk;
      logic             irq;
   } hmf_regs_t;

   localparam hmf_regs_t REGS_RST = '{
      rx_payload_byte_offset: RX_OFF_RST,
      irq_sts: IRQ_RST,
      irq_msk: IRQ_RST,
      default: '0
   };

   hmf_regs_t        q;
   hmf_regs_t        n;
   logic             wr_fire;
   logic             stop_done;
   logic             skip_done;
   logic [IRQ_W-1:0] events;

   //----------------------------------------
   // Address decode
   //----------------------------------------
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == REG_RX_CFG_LOW_OFS) || (addr == REG_TX_CFG_OFS) ||
                  (addr == REG_RX_DP_OFS) || (addr == REG_IRQ_STS_OFS) ||
                  (addr == REG_IRQ_MSK_OFS);
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] addr, input hmf_regs_t r);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (addr)
         REG_RX_CFG_LOW_OFS: d[RX_OFF_MSB:RX_OFF_LSB] = r.rx_payload_byte_offset;
         REG_TX_CFG_OFS: begin
            d[TX_SAO_BIT]  = r.tx_status_overrun_allow;
            d[TX_ON_BIT]   = r.tx_on;
            d[TX_STOP_BIT] = r.tx_stop;
         end
         REG_RX_DP_OFS:   d[RX_SKIP_BIT] = r.rx_frame_skip;
         REG_IRQ_STS_OFS: d[IRQ_W-1:0] = r.irq_sts;
         REG_IRQ_MSK_OFS: d[IRQ_W-1:0] = r.irq_msk;
         default:         d = 32'h0000_0000;
      endcase
      read_word = d;
   endfunction

   //----------------------------------------
   // Next state
   //----------------------------------------
   always_comb begin
      n = q;
      n.tx_status_flush = 1'b0;
      n.tx_data_flush = 1'b0;

      // Address and data latch in either order
      if (s_axi_awvalid_i && q.awready) begin
         n.aw_got = 1'b1;
         n.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && q.wready) begin
         n.w_got = 1'b1;
         n.w_data = s_axi_wdata_i;
         n.w_strb = s_axi_wstrb_i;
      end

      // Hardware clears ahead of software writes
      stop_done = q.tx_stop && tx_halted_i;
      if (stop_done) begin
         n.tx_stop = 1'b0;
         n.tx_on = 1'b0;
      end
      if (skip_done) begin
         n.rx_frame_skip = 1'b0;
      end

      wr_fire = q.aw_got && q.w_got && !q.bvalid;
      if (wr_fire) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = is_mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         unique case (q.aw_addr)
            REG_RX_CFG_LOW_OFS: begin
               if (q.w_strb[1]) begin
                  n.rx_payload_byte_offset = q.w_data[RX_OFF_MSB:RX_OFF_LSB];
               end
            end
            REG_TX_CFG_OFS: begin
               if (q.w_strb[1]) begin
                  n.tx_status_flush = q.w_data[TXS_FLUSH_BIT];
                  n.tx_data_flush = q.w_data[TXD_FLUSH_BIT];
               end
               if (q.w_strb[0]) begin
                  n.tx_status_overrun_allow = q.w_data[TX_SAO_BIT];
                  if (!stop_done) begin
                     n.tx_on = q.w_data[TX_ON_BIT];
                  end
                  if (!q.tx_stop) begin
                     n.tx_stop = q.w_data[TX_STOP_BIT];
                  end
               end
            end
            REG_RX_DP_OFS: begin
               if (q.w_strb[3] && q.w_data[RX_SKIP_BIT]) begin
                  n.rx_frame_skip = 1'b1;
               end
            end
            REG_IRQ_STS_OFS: begin
               if (q.w_strb[0]) begin
                  n.irq_sts = q.irq_sts & ~q.w_data[IRQ_W-1:0];
               end
            end
            REG_IRQ_MSK_OFS: begin
               if (q.w_strb[0]) begin
                  n.irq_msk = q.w_data[IRQ_W-1:0];
               end
            end
            default: begin
               n.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.bvalid && s_axi_bready_i) begin
         n.bvalid = 1'b0;
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      // Read channel, one outstanding
      if (s_axi_arvalid_i && q.arready) begin
         n.rvalid = 1'b1;
         n.rdata = read_word(s_axi_araddr_i, q);
         n.rresp = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end
      if (q.rvalid && s_axi_rready_i) begin
         n.rvalid = 1'b0;
      end
      n.arready = !n.rvalid;

      // Suspend only when overrun not allowed
      n.tx_suspend = tx_status_fifo_full_i && !n.tx_status_overrun_allow;

      // Event set wins over a same-cycle clear
      events = '0;
      events[IRQ_TSF_BIT] = tx_status_fifo_full_i;
      events[IRQ_STOP_BIT] = stop_done;
      events[IRQ_SKIP_BIT] = skip_done;
      n.irq_sts = n.irq_sts | events;
      n.irq = |(n.irq_sts & n.irq_msk);
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q <= REGS_RST;
      end else begin
         q <= n;
      end
   end

   //----------------------------------------
   // Receive offset and skip path
   //----------------------------------------
   hmf_rx_shifter u_shifter (
      .core_clk_i  (core_clk_i),
      .srst_i      (srst_i),
      .offset_i    (q.rx_payload_byte_offset),
      .skip_req_i  (q.rx_frame_skip),
      .skip_done_o (skip_done),
      .in_valid_i  (rx_in_valid_i),
      .in_data_i   (rx_in_data_i),
      .in_sof_i    (rx_in_sof_i),
      .in_ready_o  (rx_in_ready_o),
      .out_valid_o (rx_out_valid_o),
      .out_data_o  (rx_out_data_o),
      .out_sof_o   (rx_out_sof_o)
   );

   //----------------------------------------
   // Outputs
   //----------------------------------------
   assign s_axi_awready_o   = q.awready;
   assign s_axi_wready_o    = q.wready;
   assign s_axi_bvalid_o    = q.bvalid;
   assign s_axi_bresp_o     = q.bresp;
   assign s_axi_arready_o   = q.arready;
   assign s_axi_rvalid_o    = q.rvalid;
   assign s_axi_rdata_o     = q.rdata;
   assign s_axi_rresp_o     = q.rresp;
   assign tx_enable_o       = q.tx_on;
   assign tx_stop_req_o     = q.tx_stop;
   assign tx_suspend_o      = q.tx_suspend;
   assign tx_status_flush_o = q.tx_status_flush;
   assign tx_data_flush_o   = q.tx_data_flush;
   assign irq_o             = q.irq;
endmodule
`default_nettype wire

// File: sim/hmf_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module hmf_checker
   import hmf_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk_i,
   input wire logic       srst_i,
   // Register bus
   input wire logic       s_axi_awvalid_i,
   input wire logic       s_axi_awready_o,
   input wire logic       s_axi_wvalid_i,
   input wire logic       s_axi_wready_o,
   input wire logic       s_axi_bvalid_o,
   input wire logic       s_axi_arvalid_i,
   input wire logic       s_axi_arready_o,
   input wire logic       s_axi_rvalid_o,
   // Transmit
   input wire logic       tx_halted_i,
   input wire logic       tx_status_fifo_full_i,
   input wire logic       tx_enable_o,
   input wire logic       tx_stop_req_o,
   input wire logic       tx_suspend_o,
   input wire logic       tx_status_flush_o,
   input wire logic       tx_data_flush_o,
   // Receive
   input wire logic       rx_in_ready_o,
   input wire logic       rx_out_valid_o,
   input wire logic [7:0] rx_out_data_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   property p_wr_answer;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
         |-> ##[1:2] s_axi_bvalid_o;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_wr_hold; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write taken while answering");
   property p_rd_answer; s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_hold; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read taken while answering");
   property p_suspend; !tx_status_fifo_full_i |=> !tx_suspend_o; endproperty
   a_suspend: assert property (p_suspend) else $error("suspend without full");
   property p_sflush; tx_status_flush_o |-> !s_axi_awready_o ##1 !tx_status_flush_o; endproperty
   a_sflush: assert property (p_sflush) else $error("status flush pulse bad");
   property p_dflush; tx_data_flush_o |-> !s_axi_awready_o ##1 !tx_data_flush_o; endproperty
   a_dflush: assert property (p_dflush) else $error("data flush pulse bad");
   property p_stop_done; tx_stop_req_o && tx_halted_i |=> !tx_stop_req_o && !tx_enable_o; endproperty
   a_stop_done: assert property (p_stop_done) else $error("stop not cleared");
   property p_stop_hold; tx_stop_req_o && !tx_halted_i |=> tx_stop_req_o; endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop dropped early");
   property p_pad; rx_out_valid_o && !rx_in_ready_o |-> rx_out_data_o == PAD_BYTE; endproperty
   a_pad: assert property (p_pad) else $error("pad byte wrong");
endmodule
bind hmf_top hmf_checker u_chk (.*);
`default_nettype wire

// File: sim/hmf_tx_model.sv
`timescale 1ns/100ps
`default_nettype none
module hmf_tx_model (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic srst_i,
   // Transmit control
   input  wire logic tx_enable_i,
   input  wire logic tx_stop_req_i,
   output logic      tx_halted_o
);
   logic [4:0] frame_cnt;
   // Frames of 32 cycles; a stop waits for the frame end
   assign tx_halted_o = srst_i || !tx_enable_i || (tx_stop_req_i && frame_cnt == 5'h1F);
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !tx_enable_i) begin
         frame_cnt <= 5'h00;
      end else begin
         frame_cnt <= frame_cnt + 5'h01;
      end
   end
endmodule
`default_nettype wire

// File: sim/host_mac_fifo_datapath_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module host_mac_fifo_datapath_ctrl_bench
   import hmf_pkg::*;
;
   logic        core_clk_i, srst_i = 1'b1, tx_halted_i, tx_status_fifo_full_i = 1'b0;
   logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, rx_in_data_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i = 4'h0;
   logic        rx_in_valid_i = 1'b0, rx_in_sof_i = 1'b0, rx_in_ready_o, irq_o;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
   logic        s_axi_rvalid_o, rx_out_valid_o, rx_out_sof_o;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic        tx_enable_o, tx_stop_req_o, tx_suspend_o, tx_status_flush_o, tx_data_flush_o;
   logic [7:0]  rx_out_data_o;
   int          fail_count = 0, checks_done = 0, n_sf = 0, n_df = 0;
   logic [8:0]  exp_q[$], got_q[$];
   typedef struct packed {
      logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] q; logic [1:0] r;
   } hmf_row_t;
   localparam hmf_row_t ROWS [8] = '{
      '{8'h6C, 32'hFFFFFFFF, 4'hF, 32'h00001F00, 2'h0},
      '{8'h6C, 32'h00000100, 4'hF, 32'h00000100, 2'h0},
      '{8'h6C, 32'h00000000, 4'h1, 32'h00000100, 2'h0},
      '{8'h70, 32'hFFFF0004, 4'hF, 32'h00000004, 2'h0},
      '{8'h70, 32'h00000000, 4'hF, 32'h00000000, 2'h0},
      '{8'h94, 32'hFFFFFFFF, 4'hF, 32'h00000007, 2'h0},
      '{8'h40, 32'hFFFFFFFF, 4'hF, 32'h00000000, 2'h2},
      '{8'h6C, 32'h00001F00, 4'h2, 32'h00001F00, 2'h0}};
   hmf_top dut (.*);
   hmf_tx_model u_tx (
      .core_clk_i    (core_clk_i),
      .srst_i        (srst_i),
      .tx_enable_i   (tx_enable_o),
      .tx_stop_req_i (tx_stop_req_o),
      .tx_halted_o   (tx_halted_i)
   );
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      n_sf <= n_sf + int'(tx_status_flush_o);
      n_df <= n_df + int'(tx_data_flush_o);
      if (rx_out_valid_o) got_q.push_back({rx_out_sof_o, rx_out_data_o});
   end
   //----------------------------------------
   // Tasks
   //----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      @(posedge core_clk_i);
      s_axi_awvalid_i <= 1'b1;
      s_axi_awaddr_i  <= a;
      s_axi_wvalid_i  <= 1'b1;
      s_axi_wdata_i   <= d;
      s_axi_wstrb_i   <= s;
      s_axi_bready_i  <= 1'b1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      chk(32'(s_axi_bresp_o), 32'(r));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge core_clk_i);
      s_axi_arvalid_i <= 1'b1;
      s_axi_araddr_i  <= a;
      s_axi_rready_i  <= 1'b1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      chk(s_axi_rdata_o, e);
      chk(32'(s_axi_rresp_o), 32'(r));
   endtask
   // One byte; a kept frame start gets p pads first
   task automatic put(input logic [7:0] d, input logic s, input logic k, input int p);
      rx_in_valid_i <= 1'b1;
      rx_in_data_i  <= d;
      rx_in_sof_i   <= s;
      for (int j = 0; j < p && k && s; j++) exp_q.push_back({j == 0, PAD_BYTE});
      if (k) exp_q.push_back({s && p == 0, d});
      do @(posedge core_clk_i); while (rx_in_ready_o !== 1'b1);
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      print_verdict();
   end
   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk_i);
      srst_i <= 1'b0;
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d, ROWS[i].s, ROWS[i].r);
         rd(ROWS[i].a, ROWS[i].q, ROWS[i].r);
      end
      srst_i <= 1'b1;
      repeat (10) @(posedge core_clk_i);
      srst_i <= 1'b0;
      rd(REG_RX_CFG_LOW_OFS, 32'h0, RESP_OKAY);
      rd(REG_IRQ_MSK_OFS, 32'h0, RESP_OKAY);
      tx_status_fifo_full_i <= 1'b1;
      wr(REG_TX_CFG_OFS, 32'h0, 4'h1, RESP_OKAY);
      chk(32'(tx_suspend_o), 32'h1);
      wr(REG_TX_CFG_OFS, 32'h4, 4'h1, RESP_OKAY);
      chk(32'(tx_suspend_o), 32'h0);
      rd(REG_IRQ_STS_OFS, 32'h1, RESP_OKAY);
      wr(REG_IRQ_MSK_OFS, 32'h1, 4'h1, RESP_OKAY);
      chk(32'(irq_o), 32'h1);
      tx_status_fifo_full_i <= 1'b0;
      wr(REG_IRQ_STS_OFS, 32'h1, 4'h1, RESP_OKAY);
      @(posedge core_clk_i);
      chk(32'(irq_o), 32'h0);
      wr(REG_TX_CFG_OFS, 32'h2, 4'h1, RESP_OKAY);
      chk(32'(tx_enable_o), 32'h1);
      wr(REG_TX_CFG_OFS, 32'h3, 4'h1, RESP_OKAY);
      wr(REG_TX_CFG_OFS, 32'h2, 4'h1, RESP_OKAY);
      rd(REG_TX_CFG_OFS, 32'h3, RESP_OKAY);
      for (int i = 0; i < 64 && tx_stop_req_o !== 1'b0; i++) @(posedge core_clk_i);
      rd(REG_TX_CFG_OFS, 32'h0, RESP_OKAY);
      rd(REG_IRQ_STS_OFS, 32'h2, RESP_OKAY);
      wr(REG_IRQ_STS_OFS, 32'h7, 4'h1, RESP_OKAY);
      wr(REG_TX_CFG_OFS, 32'h8000, 4'h2, RESP_OKAY);
      @(posedge core_clk_i);
      chk(32'(n_sf * 256 + n_df), 32'h0100);
      wr(REG_TX_CFG_OFS, 32'h4000, 4'h2, RESP_OKAY);
      @(posedge core_clk_i);
      chk(32'(n_sf * 256 + n_df), 32'h0101);
      wr(REG_TX_CFG_OFS, 32'hC000, 4'h1, RESP_OKAY);
      @(posedge core_clk_i);
      chk(32'(n_sf * 256 + n_df), 32'h0101);
      // Offset changed only while the stream is idle
      wr(REG_RX_CFG_LOW_OFS, 32'h200, 4'h2, RESP_OKAY);
      for (int i = 0; i < 5; i++) put(8'hA0 + 8'(i), i == 0 || i == 3, 1'b1, 2);
      rx_in_valid_i <= 1'b0;
      wr(REG_RX_DP_OFS, 32'h80000000, 4'h8, RESP_OKAY);
      // Skip bit reads back one while the skip is pending
      rd(REG_RX_DP_OFS, 32'h80000000, RESP_OKAY);
      for (int i = 5; i < 9; i++) put(8'hA0 + 8'(i), i == 7, i > 6, 2);
      rx_in_valid_i <= 1'b0;
      rd(REG_RX_DP_OFS, 32'h0, RESP_OKAY);
      rd(REG_IRQ_STS_OFS, 32'h4, RESP_OKAY);
      // Offset zero, stream idle: frame start keeps its own mark
      wr(REG_RX_CFG_LOW_OFS, 32'h0, 4'h2, RESP_OKAY);
      wr(REG_RX_DP_OFS, 32'h80000000, 4'h8, RESP_OKAY);
      for (int i = 9; i < 13; i++) put(8'hA0 + 8'(i), i == 10, i > 9, 0);
      rx_in_valid_i <= 1'b0;
      rd(REG_RX_DP_OFS, 32'h0, RESP_OKAY);
      chk(32'(got_q.size()), 32'(exp_q.size()));
      foreach (exp_q[i]) chk(32'(got_q[i]), 32'(exp_q[i]));
      print_verdict();
   end
endmodule
`default_nettype wire
